/* File: inc/ocu_pkg.sv */
package ocu_pkg;

    // counter and channel geometry
    localparam int OCU_COUNT_W = 16;
    localparam int OCU_CHANNELS = 5;
    localparam int OCU_PINS = 5;
    localparam int OCU_CAPTURES = 4;
    localparam int OCU_ADDR_W = 8;

    // register byte offsets on the bus
    localparam logic [7:0] OCU_OFF_COUNT = 8'h00;
    localparam logic [7:0] OCU_OFF_CMP_BASE = 8'h04;
    localparam logic [7:0] OCU_OFF_CMP_LAST = 8'h14;
    localparam logic [7:0] OCU_OFF_FORCE = 8'h18;
    localparam logic [7:0] OCU_OFF_PMASK = 8'h1c;
    localparam logic [7:0] OCU_OFF_PDATA = 8'h20;
    localparam logic [7:0] OCU_OFF_ACTION = 8'h24;
    localparam logic [7:0] OCU_OFF_IRQ_EN = 8'h28;
    localparam logic [7:0] OCU_OFF_FLAGS = 8'h2c;
    localparam logic [7:0] OCU_OFF_PULSE_ACCUMULATOR_CONTROL = 8'h30;

    // reset values
    localparam logic [15:0] OCU_CMP_RESET = 16'hffff;
    localparam logic [15:0] OCU_COUNT_RESET = 16'h0000;
    localparam logic [7:0] OCU_BYTE_RESET = 8'h00;

    // field positions
    localparam int OCU_CH_MSB = 7;         // channel one sits at bit 7, channel five at bit 3
    localparam int OCU_CH_LSB = 3;         // bits below this are unimplemented in the force, mask and data regs
    localparam int OCU_SHARED_FLAG = 3;    // shared capture four / compare five flag
    localparam int OCU_SELECT_BIT = 2;     // shared channel select in accumulator control

    // pin action encodings
    typedef struct packed {
        logic mode;
        logic level;
    } ocu_action_t;

    localparam ocu_action_t OCU_ACT_OFF = 2'b00;
    localparam ocu_action_t OCU_ACT_TOGGLE = 2'b01;
    localparam ocu_action_t OCU_ACT_LOW = 2'b10;
    localparam ocu_action_t OCU_ACT_HIGH = 2'b11;

    // bus handshake states
    typedef enum logic [1:0] {
        OCU_BUS_IDLE = 2'b01,
        OCU_BUS_ANSWER = 2'b10
    } ocu_bus_state_t;

endpackage

/* File: rtl/ocu_compare_unit.sv */
`timescale 1ns/100ps
module ocu_compare_unit
    import ocu_pkg::*;
#(
    parameter int COUNT_W = OCU_COUNT_W
)
(
    input wire logic [COUNT_W-1:0] value_i,
    input wire logic [COUNT_W-1:0] count_i,
    input wire logic step_i,
    input wire logic inhibit_i,
    input wire logic enable_i,
    output logic match_o
);

    // equality is looked at only once per count value, and never in the cycle after a high-byte write
    assign match_o = step_i && enable_i && !inhibit_i && (value_i == count_i);

endmodule

/* File: rtl/ocu_pin_driver.sv */
`timescale 1ns/100ps
module ocu_pin_driver
    import ocu_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire ocu_action_t action_i,
    input wire logic action_fire_i,
    input wire logic pattern_fire_i,
    input wire logic pattern_mask_i,
    input wire logic pattern_level_i,
    output logic pin_o,
    output logic owned_o
);

    // pattern channel wins over the pin's own channel when both fire together
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pin_o <= 1'b0;
        end
        else if (pattern_fire_i && pattern_mask_i)
        begin
            pin_o <= pattern_level_i;
        end
        else if (action_fire_i)
        begin
            case (action_i)
                OCU_ACT_TOGGLE: pin_o <= !pin_o;
                OCU_ACT_LOW: pin_o <= 1'b0;
                OCU_ACT_HIGH: pin_o <= 1'b1;
                default: pin_o <= pin_o;
            endcase
        end
    end

    // pin is owned by the timer while a mask bit or a non-zero action claims it
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            owned_o <= 1'b0;
        end
        else
        begin
            owned_o <= pattern_mask_i || (action_i != OCU_ACT_OFF);
        end
    end

endmodule

/* File: rtl/ocu_timer_output_compare.sv */
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
// Summary of operation
// - five channels, each a 16-bit compare register and comparator against the counter.
// - a match sets the channel's compare flag in the flag register.
// - interrupt requested while a flag and its aligned enable bit are both set.
// - compare registers reset to all ones and are readable and writable; channel five takes writes only while the select bit is clear.
// - a high-byte write blocks that channel's comparison for one cycle.
// - channels two to five: 00 off, 01 toggle, 10 low, 11 high.
// - pin action happens on every match whether or not the flag was cleared.
// - channel five compares only while the shared select bit is clear.
// - channel one match drives data bits onto pins whose mask bit is set.
// - mask and data bits 2 to 0 are unimplemented and read zero.
// - force bit one fires pin action without flag; zero does nothing; low bits read zero.
// - forced action lands at the next counter transition after the write.
// - counter is read-only; high-byte read latches low byte for the next read.
// - shared enable bit serves capture four or compare five by the select bit.
// - enable bits for captures one to three request interrupts with their flags.
// - full 16-bit access is coherent; separate byte accesses are still accepted.
// - flags clear only by writing one; writing zero leaves them alone.
// - select bit one chooses capture four, zero chooses compare five.
module ocu_timer_output_compare
    import ocu_pkg::*;
#(
    parameter int COUNT_W = OCU_COUNT_W
)
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic count_tick_i,
    input wire logic [OCU_CAPTURES-1:0] capture_event_i,
    input wire logic [OCU_ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic [OCU_PINS-1:0] compare_port_pins_o,
    output logic [OCU_PINS-1:0] compare_pin_owned_o,
    output logic [COUNT_W-1:0] free_running_count_o,
    output logic irq_o
);

    // the byte-wide register map assumes exactly a 16-bit counter
    if (COUNT_W != 16)
    begin : g_bad_width
        $error("ocu_timer_output_compare: COUNT_W must be 16");
    end

    ocu_bus_state_t bus_state;
    logic [COUNT_W-1:0] compare_value [OCU_CHANNELS];
    logic [COUNT_W-1:0] count;
    logic count_step;
    logic [OCU_CHANNELS-1:0] inhibit;
    logic [OCU_CHANNELS-1:0] match;
    logic [OCU_CHANNELS-1:0] force_pending;
    logic [OCU_CHANNELS-1:0] fire;
    logic [7:0] pattern_pin_mask;
    logic [7:0] pattern_pin_data;
    logic [7:0] compare_pin_action;
    logic [7:0] capture_compare_irq_enable;
    logic [7:0] capture_compare_flags;
    logic [7:0] next_flags;
    logic [7:0] flag_set;
    logic shared_channel_select;
    logic [7:0] count_low_buffer;
    logic count_low_valid;
    logic accept_write;
    logic take_read;
    logic cmp_hit;
    logic [2:0] cmp_index;
    logic [7:0] cmp_offset;
    logic [31:0] next_readdata;

    // one request is taken per idle cycle; writes land at the edge where waitrequest is low
    assign take_read = (bus_state == OCU_BUS_IDLE) && avs_read_i;
    assign accept_write = (bus_state == OCU_BUS_ANSWER) && avs_write_i;

    // compare register window decode
    assign cmp_offset = avs_address_i - OCU_OFF_CMP_BASE;
    assign cmp_hit = (avs_address_i >= OCU_OFF_CMP_BASE) && (avs_address_i <= OCU_OFF_CMP_LAST)
                     && (avs_address_i[1:0] == 2'b00);
    assign cmp_index = cmp_offset[4:2];

    // bus handshake: waitrequest low for exactly one cycle per request
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            bus_state <= OCU_BUS_IDLE;
            avs_waitrequest_o <= 1'b1;
        end
        else
        begin
            case (bus_state)
                OCU_BUS_IDLE:
                begin
                    if (avs_read_i || avs_write_i)
                    begin
                        bus_state <= OCU_BUS_ANSWER;
                        avs_waitrequest_o <= 1'b0;
                    end
                end
                OCU_BUS_ANSWER:
                begin
                    bus_state <= OCU_BUS_IDLE;
                    avs_waitrequest_o <= 1'b1;
                end
                default:
                begin
                    bus_state <= OCU_BUS_IDLE;
                    avs_waitrequest_o <= 1'b1;
                end
            endcase
        end
    end

    // free-running counter; software has no write path to it
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            count <= OCU_COUNT_RESET;
            count_step <= 1'b0;
        end
        else
        begin
            if (count_tick_i)
            begin
                count <= COUNT_W'(count + 1'b1);
            end
            count_step <= count_tick_i;
        end
    end

    // per-channel storage, write inhibit and comparator
    for (genvar ch = 0; ch < OCU_CHANNELS; ch++)
    begin : g_channel
        logic chan_write;
        logic shared_capture;

        assign chan_write = accept_write && cmp_hit && (cmp_index == 3'(ch));
        assign shared_capture = (ch == OCU_CHANNELS - 1) && shared_channel_select;

        // byte lanes may be written separately; capture four owns the shared register when selected
        always_ff @(posedge sys_clk_i or negedge rst_n_i)
        begin
            if (!rst_n_i)
            begin
                compare_value[ch] <= OCU_CMP_RESET;
            end
            else if (shared_capture)
            begin
                if (capture_event_i[OCU_CAPTURES-1])
                begin
                    compare_value[ch] <= count;
                end
            end
            else if (chan_write)
            begin
                if (avs_byteenable_i[0])
                begin
                    compare_value[ch][7:0] <= avs_writedata_i[7:0];
                end
                if (avs_byteenable_i[1])
                begin
                    compare_value[ch][15:8] <= avs_writedata_i[15:8];
                end
            end
        end

        // high-byte write holds off the comparison in the following cycle
        always_ff @(posedge sys_clk_i or negedge rst_n_i)
        begin
            if (!rst_n_i)
            begin
                inhibit[ch] <= 1'b0;
            end
            else
            begin
                inhibit[ch] <= chan_write && avs_byteenable_i[1];
            end
        end

        ocu_compare_unit #(
            .COUNT_W(COUNT_W)
        ) u_compare (
            .value_i(compare_value[ch]),
            .count_i(count),
            .step_i(count_step),
            .inhibit_i(inhibit[ch]),
            .enable_i(!shared_capture),
            .match_o(match[ch])
        );

        // a match or a pending force fires the pin action at a count transition
        assign fire[ch] = match[ch] || (force_pending[OCU_CHANNELS-1-ch] && count_step && !shared_capture);
    end

    // force requests wait for the next counter transition, then clear
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            force_pending <= '0;
        end
        else
        begin
            force_pending <= (force_pending & ~{OCU_CHANNELS{count_step}})
                             | ({OCU_CHANNELS{accept_write && avs_address_i == OCU_OFF_FORCE
                                 && avs_byteenable_i[0]}}
                                & avs_writedata_i[OCU_CH_MSB:OCU_CH_LSB]);
        end
    end

    // pattern mask and data, pin actions, interrupt enables and shared select
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pattern_pin_mask <= OCU_BYTE_RESET;
            pattern_pin_data <= OCU_BYTE_RESET;
            compare_pin_action <= OCU_BYTE_RESET;
            capture_compare_irq_enable <= OCU_BYTE_RESET;
            shared_channel_select <= 1'b0;
        end
        else if (accept_write && avs_byteenable_i[0])
        begin
            case (avs_address_i)
                OCU_OFF_PMASK: pattern_pin_mask <= {avs_writedata_i[7:3], 3'h0};
                OCU_OFF_PDATA: pattern_pin_data <= {avs_writedata_i[7:3], 3'h0};
                OCU_OFF_ACTION: compare_pin_action <= avs_writedata_i[7:0];
                OCU_OFF_IRQ_EN: capture_compare_irq_enable <= avs_writedata_i[7:0];
                OCU_OFF_PULSE_ACCUMULATOR_CONTROL: shared_channel_select <= avs_writedata_i[OCU_SELECT_BIT];
                default: shared_channel_select <= shared_channel_select;
            endcase
        end
    end

    // flag sources: compare matches in bits 7..4, compare five or capture four in bit 3, captures one to three in bits 2..0
    always_comb
    begin
        flag_set = 8'h00;
        for (int k = 0; k < OCU_CHANNELS - 1; k++)
        begin
            flag_set[OCU_CH_MSB - k] = match[k];
        end
        flag_set[OCU_SHARED_FLAG] = shared_channel_select ? capture_event_i[OCU_CAPTURES-1]
                                                          : match[OCU_CHANNELS-1];
        flag_set[2] = capture_event_i[0];
        flag_set[1] = capture_event_i[1];
        flag_set[0] = capture_event_i[2];
    end

    // write-one-to-clear, with a new event winning over a clear in the same cycle
    always_comb
    begin
        next_flags = capture_compare_flags;
        if (accept_write && avs_address_i == OCU_OFF_FLAGS && avs_byteenable_i[0])
        begin
            next_flags = next_flags & ~avs_writedata_i[7:0];
        end
        next_flags = next_flags | flag_set;
    end

    // flag register and interrupt request
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            capture_compare_flags <= 8'h00;
            irq_o <= 1'b0;
        end
        else
        begin
            capture_compare_flags <= next_flags;
            irq_o <= |(next_flags & capture_compare_irq_enable);
        end
    end

    // port pins: pin 4 is pattern-only, pins 3..0 belong to channels two to five
    for (genvar p = 0; p < OCU_PINS; p++)
    begin : g_pin
        ocu_action_t pin_action;
        logic pin_fire;

        if (p == OCU_PINS - 1)
        begin : g_pattern_only
            assign pin_action = OCU_ACT_OFF;
            assign pin_fire = 1'b0;
        end
        else
        begin : g_channel_pin
            assign pin_action = compare_pin_action[2*p+1 -: 2];
            assign pin_fire = fire[OCU_CHANNELS-1-p];
        end

        ocu_pin_driver u_pin (
            .sys_clk_i(sys_clk_i),
            .rst_n_i(rst_n_i),
            .action_i(pin_action),
            .action_fire_i(pin_fire),
            .pattern_fire_i(fire[0]),
            .pattern_mask_i(pattern_pin_mask[OCU_CH_LSB+p]),
            .pattern_level_i(pattern_pin_data[OCU_CH_LSB+p]),
            .pin_o(compare_port_pins_o[p]),
            .owned_o(compare_pin_owned_o[p])
        );
    end

    // counter low-byte buffer filled by a high-byte-only read, used by the next low-byte-only read
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            count_low_buffer <= 8'h00;
            count_low_valid <= 1'b0;
        end
        else if (take_read && avs_address_i == OCU_OFF_COUNT)
        begin
            if (avs_byteenable_i[1] && !avs_byteenable_i[0])
            begin
                count_low_buffer <= count[7:0];
                count_low_valid <= 1'b1;
            end
            else if (avs_byteenable_i[0])
            begin
                count_low_valid <= 1'b0;
            end
        end
    end

    // read multiplexer; unmapped offsets read zero
    always_comb
    begin
        next_readdata = 32'h0000_0000;
        if (cmp_hit)
        begin
            next_readdata[15:0] = compare_value[cmp_index];
        end
        else
        begin
            case (avs_address_i)
                OCU_OFF_COUNT:
                begin
                    next_readdata[15:0] = count;
                    if (count_low_valid && avs_byteenable_i[0] && !avs_byteenable_i[1])
                    begin
                        next_readdata[7:0] = count_low_buffer;
                    end
                end
                OCU_OFF_FORCE: next_readdata[7:0] = {force_pending, 3'h0};
                OCU_OFF_PMASK: next_readdata[7:0] = pattern_pin_mask;
                OCU_OFF_PDATA: next_readdata[7:0] = pattern_pin_data;
                OCU_OFF_ACTION: next_readdata[7:0] = compare_pin_action;
                OCU_OFF_IRQ_EN: next_readdata[7:0] = capture_compare_irq_enable;
                OCU_OFF_FLAGS: next_readdata[7:0] = capture_compare_flags;
                OCU_OFF_PULSE_ACCUMULATOR_CONTROL: next_readdata[OCU_SELECT_BIT] = shared_channel_select;
                default: next_readdata = 32'h0000_0000;
            endcase
        end
    end

    // read data is captured as the request is taken and stands while waitrequest is low
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            avs_readdata_o <= 32'h0000_0000;
        end
        else if (take_read)
        begin
            avs_readdata_o <= next_readdata;
        end
    end

    // counter copy for the outside world
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            free_running_count_o <= OCU_COUNT_RESET;
        end
        else
        begin
            free_running_count_o <= count_tick_i ? COUNT_W'(count + 1'b1) : count;
        end
    end

endmodule

/* File: tb/ocu_timer_output_compare_monitor.sv */
`timescale 1ns/100ps
module ocu_timer_output_compare_monitor
    import ocu_pkg::*;
#(
    parameter int COUNT_W = OCU_COUNT_W
)
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic count_tick_i,
    input wire logic [OCU_CAPTURES-1:0] capture_event_i,
    input wire logic [OCU_ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [OCU_PINS-1:0] compare_port_pins_o,
    input wire logic [OCU_PINS-1:0] compare_pin_owned_o,
    input wire logic [COUNT_W-1:0] free_running_count_o,
    input wire logic irq_o
);
    default clocking mon_cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // request seen while the slave is idle
    sequence seq_taken;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence seq_read_taken;
        avs_read_i && avs_waitrequest_o;
    endsequence

    chk_wait_one: assert property (seq_taken |=> !avs_waitrequest_o)
        else $error("bus answer late");
    chk_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    chk_count_step: assert property (count_tick_i |=> free_running_count_o == $past(free_running_count_o) + 1'b1)
        else $error("count did not advance");
    chk_count_hold: assert property (!count_tick_i |=> $stable(free_running_count_o))
        else $error("count moved without tick");
    chk_unmapped_zero: assert property
        (seq_read_taken ##0 (avs_address_i > 8'h30 || avs_address_i[1:0] != 2'b00) |=> avs_readdata_o == 32'h0)
        else $error("unmapped read not zero");
    chk_low_bits_zero: assert property
        (seq_read_taken ##0 (avs_address_i inside {8'h18, 8'h1c, 8'h20}) |=> avs_readdata_o[2:0] == 3'h0)
        else $error("unimplemented bits not zero");
    chk_rdata_hold: assert property ($changed(avs_readdata_o) |-> $past(avs_read_i && avs_waitrequest_o))
        else $error("read data changed without read");
    chk_pin_step: assert property ($changed(compare_port_pins_o) |-> $past(count_tick_i, 2))
        else $error("pin changed off a count step");
    chk_owned_write: assert property ($changed(compare_pin_owned_o) |->
        ($past(avs_write_i && !avs_waitrequest_o) || $past(avs_write_i && !avs_waitrequest_o, 2)))
        else $error("pin ownership changed without write");
endmodule

bind ocu_timer_output_compare ocu_timer_output_compare_monitor #(.COUNT_W(COUNT_W)) i_monitor (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .count_tick_i(count_tick_i), .capture_event_i(capture_event_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .compare_port_pins_o(compare_port_pins_o),
    .compare_pin_owned_o(compare_pin_owned_o), .free_running_count_o(free_running_count_o), .irq_o(irq_o));

/* File: tb/ocu_timer_output_compare_tb_top.sv */
`timescale 1ns/100ps
module ocu_timer_output_compare_tb_top
    import ocu_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic count_tick = 1'b0;
    logic [3:0] capture_event = 4'h0;
    logic [7:0] address = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'h0;
    logic [31:0] rdata;
    logic waitreq;
    logic [4:0] pins;
    logic [4:0] owned;
    logic [15:0] count;
    logic irq;
    int failures = 0;
    int checked = 0;
    logic [15:0] cnt = 16'h0;
    logic [63:0] exp_q[$];
    logic [63:0] note;
    logic [7:0] a;
    logic [15:0] v;
    logic [7:0] latched;
    int i;

    ocu_timer_output_compare i_dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .count_tick_i(count_tick),
        .capture_event_i(capture_event), .avs_address_i(address), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .compare_port_pins_o(pins), .compare_pin_owned_o(owned), .free_running_count_o(count), .irq_o(irq));

    // free-running bench clock
    always #2 sys_clk = ~sys_clk;

    task automatic finish_test();
        if (failures == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one bus access; reads leave their expectation in the queue
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic [3:0] b,
                       input logic [31:0] e, input logic [31:0] m);
        int n;
        @(posedge sys_clk);
        address <= ad;
        wdata <= d;
        be <= b;
        wr <= w;
        rd <= ~w;
        if (!w)
            exp_q.push_back({e, m});
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (waitreq !== 1'b0 && n < 20);
        if (n >= 20)
            compare({31'h0, waitreq}, 32'h0);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic wr8(input logic [7:0] ad, input logic [7:0] d);
        bus(1'b1, ad, {24'h0, d}, 4'b0001, 32'h0, 32'h0);
    endtask

    task automatic wr16(input logic [7:0] ad, input logic [15:0] d);
        bus(1'b1, ad, {16'h0, d}, 4'b0011, 32'h0, 32'h0);
    endtask

    task automatic rd_chk(input logic [7:0] ad, input logic [3:0] b, input logic [31:0] e, input logic [31:0] m);
        bus(1'b0, ad, 32'h0, b, e, m);
    endtask

    task automatic settle();
        @(posedge sys_clk);
        #1;
    endtask

    // n counter ticks, then wait past the step cycle
    task automatic tick_n(input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            count_tick <= 1'b1;
            cnt++;
            @(posedge sys_clk);
            count_tick <= 1'b0;
        end
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    // read result watcher: oldest note against the data at completion
    always @(posedge sys_clk)
    begin
        if (rd && waitreq === 1'b0 && exp_q.size() > 0)
        begin
            note = exp_q.pop_front();
            compare(rdata & note[31:0], note[63:32] & note[31:0]);
        end
    end

    // hang guard
    initial
    begin
        #40000;
        failures++;
        finish_test();
    end

    // main sequence
    initial
    begin
        void'($urandom(32'hdf923e83));
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1 compare({21'h0, irq, owned, pins}, 32'h0);
        for (i = 0; i < 5; i++)
        begin
            a = OCU_OFF_CMP_BASE + 8'(4 * i);
            rd_chk(a, 4'hf, 32'h0000ffff, 32'hffffffff);
            v = 16'($urandom()) | 16'h8000;
            wr16(a, v);
            rd_chk(a, 4'hf, {16'h0, v}, 32'hffffffff);
            bus(1'b1, a, 32'h000000c3, 4'b0001, 32'h0, 32'h0);
            rd_chk(a, 4'hf, {16'h0, v[15:8], 8'hc3}, 32'hffffffff);
            bus(1'b1, a, 32'h00009600, 4'b0010, 32'h0, 32'h0);
            rd_chk(a, 4'hf, 32'h000096c3, 32'hffffffff);
        end
        for (i = 0; i < 7; i++)
            rd_chk(OCU_OFF_FORCE + 8'(4 * i), 4'hf, 32'h0, 32'hffffffff);
        rd_chk(8'h3c, 4'hf, 32'h0, 32'hffffffff);
        rd_chk(8'h06, 4'hf, 32'h0, 32'hffffffff);
        // counter is read-only, high-byte read latches the low byte
        tick_n(5);
        compare({16'h0, count}, {16'h0, cnt});
        wr16(OCU_OFF_COUNT, 16'h1234);
        rd_chk(OCU_OFF_COUNT, 4'b0010, {16'h0, cnt}, 32'h0000ff00);
        latched = cnt[7:0];
        tick_n(3);
        rd_chk(OCU_OFF_COUNT, 4'b0001, {24'h0, latched}, 32'h000000ff);
        rd_chk(OCU_OFF_COUNT, 4'b0011, {16'h0, cnt}, 32'h0000ffff);
        // channels two to five: toggle, low, high, off on one match
        for (i = 1; i < 5; i++)
            wr16(OCU_OFF_CMP_BASE + 8'(4 * i), cnt + 16'h2);
        wr8(OCU_OFF_ACTION, 8'h6c);
        wr8(OCU_OFF_IRQ_EN, 8'h40);
        tick_n(2);
        compare({27'h0, pins}, 32'h0a);
        compare({27'h0, owned}, 32'h0e);
        compare({31'h0, irq}, 32'h1);
        wr16(OCU_OFF_CMP_BASE + 8'h4, cnt + 16'h1);
        tick_n(1);
        compare({27'h0, pins}, 32'h02);
        rd_chk(OCU_OFF_FLAGS, 4'hf, 32'h78, 32'hff);
        wr8(OCU_OFF_FLAGS, 8'h00);
        rd_chk(OCU_OFF_FLAGS, 4'hf, 32'h78, 32'hff);
        wr8(OCU_OFF_FLAGS, 8'h40);
        rd_chk(OCU_OFF_FLAGS, 4'hf, 32'h38, 32'hff);
        settle();
        compare({31'h0, irq}, 32'h0);
        // pattern channel drives masked data onto all five pins
        wr8(OCU_OFF_PMASK, 8'hff);
        rd_chk(OCU_OFF_PMASK, 4'hf, 32'hf8, 32'hffffffff);
        wr8(OCU_OFF_PDATA, 8'haf);
        rd_chk(OCU_OFF_PDATA, 4'hf, 32'ha8, 32'hffffffff);
        wr16(OCU_OFF_CMP_BASE, cnt + 16'h1);
        tick_n(1);
        compare({27'h0, pins}, 32'h15);
        compare({27'h0, owned}, 32'h1f);
        rd_chk(OCU_OFF_FLAGS, 4'hf, 32'h80, 32'h80);
        // forced drive-high on channel two, never forcing a toggling channel
        wr8(OCU_OFF_FLAGS, 8'hff);
        wr8(OCU_OFF_PMASK, 8'h00);
        wr8(OCU_OFF_ACTION, 8'hc0);
        wr8(OCU_OFF_FORCE, 8'h47);
        rd_chk(OCU_OFF_FORCE, 4'hf, 32'h40, 32'hffffffff);
        repeat (4) settle();
        compare({31'h0, pins[3]}, 32'h0);
        tick_n(1);
        compare({31'h0, pins[3]}, 32'h1);
        rd_chk(OCU_OFF_FORCE, 4'hf, 32'h0, 32'hffffffff);
        rd_chk(OCU_OFF_FLAGS, 4'hf, 32'h0, 32'hff);
        // shared channel switched over to capture four
        v = cnt + 16'h1;
        wr16(OCU_OFF_CMP_LAST, v);
        wr8(OCU_OFF_ACTION, 8'h02);
        wr8(OCU_OFF_PULSE_ACCUMULATOR_CONTROL, 8'h04);
        wr16(OCU_OFF_CMP_LAST, 16'h1234);
        rd_chk(OCU_OFF_CMP_LAST, 4'hf, {16'h0, v}, 32'hffffffff);
        tick_n(1);
        compare({31'h0, pins[0]}, 32'h1);
        rd_chk(OCU_OFF_FLAGS, 4'hf, 32'h0, 32'hff);
        wr8(OCU_OFF_IRQ_EN, 8'h08);
        @(posedge sys_clk);
        capture_event <= 4'hf;
        @(posedge sys_clk);
        capture_event <= 4'h0;
        repeat (3) settle();
        compare({31'h0, irq}, 32'h1);
        rd_chk(OCU_OFF_FLAGS, 4'hf, 32'h0f, 32'hff);
        wr8(OCU_OFF_FLAGS, 8'h08);
        settle();
        compare({31'h0, irq}, 32'h0);
        wr8(OCU_OFF_IRQ_EN, 8'h07);
        settle();
        compare({31'h0, irq}, 32'h1);
        @(posedge sys_clk);
        count_tick <= 1'b1;
        wr16(OCU_OFF_CMP_BASE + 8'h8, cnt + 16'h3);
        count_tick <= 1'b0;
        rd_chk(OCU_OFF_FLAGS, 4'hf, 32'h0, 32'h20);
        finish_test();
    end
endmodule
